// ===== hdl/bspf_map.vh
// Purpose: Offsets, field positions, reset values and timing counts
//          for the boot self-programming flash controller.
// Assumes: 125 MHz core clock, 8-bit register port.
// Notes:   Definitions only; included by bare name.
`ifndef BSPF_MAP_VH
`define BSPF_MAP_VH

// ----
// Register offsets
// ----
`define BSPF_OFF_CTRL      8'h00
`define BSPF_OFF_PTR_LO    8'h01
`define BSPF_OFF_PTR_HI    8'h02
`define BSPF_OFF_DATA_LO   8'h03
`define BSPF_OFF_DATA_HI   8'h04
`define BSPF_OFF_STORE_GO  8'h05
`define BSPF_OFF_INFO      8'h06

// ----
// Control/status field positions and reset value
// ----
`define BSPF_BIT_CMD_EN    0
`define BSPF_BIT_ERASE     1
`define BSPF_BIT_WRITE     2
`define BSPF_BIT_REEN      4
`define BSPF_BIT_RWW_BUSY  6
`define BSPF_CTRL_RST      8'h00

// ----
// Timing
// ----
// Least programming time, 3.7 ms, in 8 ns cycles
`define BSPF_PROG_CYC      19'd462500
`define BSPF_CMD_WINDOW    3'd4

// ----
// Address map of the two variants
// ----
`define BSPF_SMALL_MASK    14'h1FFF
`define BSPF_SMALL_NO_READ_WHILE_WRITE_SECTION    14'h1C00
`define BSPF_MID_NO_READ_WHILE_WRITE_SECTION      14'h3800
`define BSPF_SMALL_BOOT11  14'h1F80
`define BSPF_SMALL_BOOT10  14'h1F00
`define BSPF_SMALL_BOOT01  14'h1E00
`define BSPF_SMALL_BOOT00  14'h1C00
`define BSPF_MID_BOOT11    14'h3F00
`define BSPF_MID_BOOT10    14'h3E00
`define BSPF_MID_BOOT01    14'h3C00
`define BSPF_MID_BOOT00    14'h3800
`define BSPF_PAGE_WORDS    64

`endif

// ===== hdl/bspf_timer.v
// Purpose: One-shot programming timer for erase and write operations.
// Assumes: start is a one-cycle pulse, ignored while running.
// Notes:   Count derived from the least programming time.
`timescale 1ns/1ps
`include "bspf_map.vh"

module bspf_timer #(
  parameter [18:0] CYCLES = `BSPF_PROG_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Control
  input  wire        start,
  output reg         busy_reg,
  output reg         done_reg
);

  reg [18:0] count_reg;

  // ----
  // Down counter
  // ----
  // Done pulses one cycle after the last counted cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 19'h00000;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg && start) begin
        count_reg <= CYCLES - 19'h00001;
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        if (count_reg == 19'h00000) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg - 19'h00001;
        end
      end
    end
  end

endmodule

// ===== hdl/bspf_sect.v
// Purpose: Boot section start and read-while-write limit decoding.
// Assumes: Fuse and variant inputs already stable.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "bspf_map.vh"

module bspf_sect (
  // Configuration
  input  wire        variant_mid,
  input  wire [1:0]  boot_sel,
  // Address under test
  input  wire [13:0] addr,
  // Results
  output reg  [13:0] boot_start,
  output reg         in_no_read_while_write_section
);

  // ----
  // Decode
  // ----
  // Small part ignores the top address bit: 13-bit counter
  always @* begin
    if (variant_mid) begin
      case (boot_sel) // [RULE18]
        2'b11:   boot_start = `BSPF_MID_BOOT11;
        2'b10:   boot_start = `BSPF_MID_BOOT10;
        2'b01:   boot_start = `BSPF_MID_BOOT01;
        default: boot_start = `BSPF_MID_BOOT00;
      endcase
      in_no_read_while_write_section = (addr >= `BSPF_MID_NO_READ_WHILE_WRITE_SECTION);
    end else begin
      case (boot_sel) // [RULE16]
        2'b11:   boot_start = `BSPF_SMALL_BOOT11;
        2'b10:   boot_start = `BSPF_SMALL_BOOT10;
        2'b01:   boot_start = `BSPF_SMALL_BOOT01;
        default: boot_start = `BSPF_SMALL_BOOT00;
      endcase
      in_no_read_while_write_section = ((addr & `BSPF_SMALL_MASK) >= `BSPF_SMALL_NO_READ_WHILE_WRITE_SECTION); // [RULE12] [RULE17]
    end
  end

endmodule

// ===== hdl/bspf_ctrl.v
// Purpose: Self-programming sequencer for on-chip program flash.
// Assumes: Boot software drives the register port; fuse and variant
//          straps come from pins; EEPROM busy is on the same clock.
// Notes:   Store-program instruction is a write to the go offset.
`timescale 1ns/1ps
`include "bspf_map.vh"

// Summary of operation
// [RULE1] Only no-read-while-write fetches during programming
// [RULE2] Busy flag held until re-enable completes
// [RULE3] Software polls enable clear before next command
// [RULE4] Software waits for EEPROM write idle first
// [RULE5] Software masks interrupts around timed sequence
// [RULE6] Interrupts never vector into busy section
// [RULE7] Erase bit plus enable, then store erases page
// [RULE8] Write bit plus enable, then store writes page
// [RULE9] Enable alone loads r1:r0 into buffer word
// [RULE10] Re-enable command makes section readable again
// [RULE11] Read-back verify only after re-enable
// [RULE12] Small variant counter is 13 bits wide
// [RULE13] Page select from upper pointer bits
// [RULE14] Word select from pointer bits six to one
// [RULE15] Pointer bit zero must be zero
// [RULE16] Small variant boot size fuse decode
// [RULE17] Small variant section limit at 0x1C00
// [RULE18] Mid variant boot size fuse decode
// [RULE19] Store within four cycles or command lapses
// [RULE20] Erase or write lasts 3.7 to 4.5 ms
// [RULE21] EEPROM write blocks all flash programming
// [RULE22] Enable bit self-clears when operation completes
module bspf_ctrl #(
  parameter [18:0] PROG_CYCLES = `BSPF_PROG_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_reg,
  // EEPROM status, same clock
  input  wire        eeprom_write_busy,
  // Straps from pins
  input  wire        boot_size_sel_hi,
  input  wire        boot_size_sel_lo,
  input  wire        variant_mid_pin,
  // Instruction fetch check
  input  wire        fetch_req,
  input  wire [13:0] fetch_addr,
  output reg         fetch_ok_reg,
  output reg         fetch_deny_reg,
  // Flash array side
  output reg         flash_erase_go_reg,
  output reg         flash_write_go_reg,
  output reg  [7:0]  flash_page_reg,
  input  wire [5:0]  flash_buf_idx,
  output reg  [15:0] flash_buf_data_reg,
  // Status
  output reg         rww_section_busy_reg,
  output reg  [13:0] boot_start_reg
);

  // ----
  // Declarations
  // ----
  reg  [2:0]  strap_s1_reg;
  reg  [2:0]  strap_s2_reg;
  reg  [2:0]  strap_s3_reg;
  reg  [2:0]  strap_reg;
  reg         selfprog_cmd_enable_reg;
  reg         page_erase_cmd_reg;
  reg         page_write_cmd_reg;
  reg         rww_section_reenable_reg;
  reg  [2:0]  window_reg;
  reg  [15:0] ptr_reg;
  reg  [15:0] data_reg;
  reg  [15:0] page_buf_reg [0:`BSPF_PAGE_WORDS-1];
  reg         buf_load_reg;
  wire        variant_mid;
  wire [1:0]  boot_sel;
  wire        timer_busy;
  wire        timer_done;
  wire        ctrl_wr;
  wire        go_wr;
  wire        cmd_live;
  wire        go_erase;
  wire        go_write;
  wire        go_load;
  wire        go_reen;
  wire [5:0]  word_select_field;
  wire [7:0]  page_select_field;
  wire [7:0]  ctrl_view;
  wire [13:0] sect_boot_start;
  wire        sect_in_no_read_while_write_section;

  // ----
  // Strap synchronisers
  // ----
  // Straps come from pins: three stages, accepted once 2nd and 3rd agree
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_s1_reg <= 3'h0;
      strap_s2_reg <= 3'h0;
      strap_s3_reg <= 3'h0;
      strap_reg    <= 3'h0;
    end else begin
      strap_s1_reg <= {variant_mid_pin, boot_size_sel_hi, boot_size_sel_lo};
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      if (strap_s2_reg == strap_s3_reg) begin
        strap_reg <= strap_s3_reg;
      end
    end
  end

  assign variant_mid = strap_reg[2];
  assign boot_sel    = strap_reg[1:0];

  // ----
  // Pointer field split
  // ----
  // Small part has a 7-bit page field, so the top pointer bit is dropped
  assign word_select_field = ptr_reg[6:1]; // [RULE14]
  assign page_select_field = variant_mid ? ptr_reg[14:7]
                                         : {1'b0, ptr_reg[13:7]}; // [RULE13] [RULE12]

  // ----
  // Command decode
  // ----
  // A control write is refused while a command is armed or EEPROM busy
  assign ctrl_wr  = reg_wr && (reg_addr == `BSPF_OFF_CTRL)
                    && !selfprog_cmd_enable_reg
                    && !eeprom_write_busy; // [RULE3] [RULE4] [RULE21]
  assign go_wr    = reg_wr && (reg_addr == `BSPF_OFF_STORE_GO);
  // Armed, inside the window, and pointer bit zero clear
  assign cmd_live = go_wr && selfprog_cmd_enable_reg && (window_reg != 3'h0)
                    && !timer_busy && !eeprom_write_busy
                    && !ptr_reg[0]; // [RULE19] [RULE15] [RULE21]
  assign go_erase = cmd_live && page_erase_cmd_reg; // [RULE7]
  assign go_write = cmd_live && page_write_cmd_reg; // [RULE8]
  assign go_reen  = cmd_live && rww_section_reenable_reg; // [RULE10]
  assign go_load  = cmd_live && !page_erase_cmd_reg && !page_write_cmd_reg
                    && !rww_section_reenable_reg; // [RULE9]

  // ----
  // Programming timer
  // ----
  bspf_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (go_erase | go_write), // [RULE20]
    .busy_reg (timer_busy),
    .done_reg (timer_done)
  );

  // ----
  // Section decoder
  // ----
  bspf_sect u_sect (
    .variant_mid (variant_mid),
    .boot_sel    (boot_sel),
    .addr        (fetch_addr),
    .boot_start  (sect_boot_start),
    .in_no_read_while_write_section     (sect_in_no_read_while_write_section)
  );

  // ----
  // Control and status register
  // ----
  // Enable stays set while an erase or write armed without re-enable runs, so polling sees the op
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selfprog_cmd_enable_reg  <= 1'b0;
      page_erase_cmd_reg       <= 1'b0;
      page_write_cmd_reg       <= 1'b0;
      rww_section_reenable_reg <= 1'b0;
      window_reg               <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        selfprog_cmd_enable_reg  <= reg_wdata[`BSPF_BIT_CMD_EN];
        page_erase_cmd_reg       <= reg_wdata[`BSPF_BIT_ERASE];
        page_write_cmd_reg       <= reg_wdata[`BSPF_BIT_WRITE];
        rww_section_reenable_reg <= reg_wdata[`BSPF_BIT_REEN];
        window_reg <= reg_wdata[`BSPF_BIT_CMD_EN] ? `BSPF_CMD_WINDOW : 3'h0;
      end else if (timer_done) begin
        selfprog_cmd_enable_reg <= 1'b0; // [RULE22]
        page_erase_cmd_reg      <= 1'b0;
        page_write_cmd_reg      <= 1'b0;
      end else if (go_load || go_reen) begin
        selfprog_cmd_enable_reg  <= 1'b0; // [RULE22]
        rww_section_reenable_reg <= 1'b0;
        window_reg               <= 3'h0;
      end else if (go_erase || go_write) begin
        window_reg <= 3'h0;
      end else if (window_reg == 3'h1) begin
        // Store missed its window: the command lapses
        selfprog_cmd_enable_reg  <= 1'b0; // [RULE19]
        page_erase_cmd_reg       <= 1'b0;
        page_write_cmd_reg       <= 1'b0;
        rww_section_reenable_reg <= 1'b0;
        window_reg               <= 3'h0;
      end else if (window_reg != 3'h0) begin
        window_reg <= window_reg - 3'h1;
      end
    end
  end

  // ----
  // Read-while-write section busy flag
  // ----
  // Set wins over clear; clear waits for a re-enable with no op running
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rww_section_busy_reg <= 1'b0;
    end else if (go_erase || go_write) begin
      rww_section_busy_reg <= 1'b1; // [RULE2]
    end else if (go_reen) begin
      rww_section_busy_reg <= 1'b0; // [RULE2] [RULE10]
    end
  end

  // ----
  // Pointer and data holding registers
  // ----
  // Stand-ins for the pointer pair and r1:r0 seen by the store
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_reg  <= 16'h0000;
      data_reg <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `BSPF_OFF_PTR_LO:  ptr_reg[7:0]   <= reg_wdata;
        `BSPF_OFF_PTR_HI:  ptr_reg[15:8]  <= reg_wdata;
        `BSPF_OFF_DATA_LO: data_reg[7:0]  <= reg_wdata;
        `BSPF_OFF_DATA_HI: data_reg[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----
  // Temporary page buffer
  // ----
  // One flop word per entry; held during page write so the array
  // reads a steady image
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_load_reg <= 1'b0;
    end else begin
      buf_load_reg <= go_load;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BSPF_PAGE_WORDS; gi = gi + 1) begin : g_buf
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          page_buf_reg[gi] <= 16'h0000;
        end else if (go_load && ({26'h0000000, word_select_field} == gi)) begin
          page_buf_reg[gi] <= data_reg; // [RULE9] [RULE14]
        end
      end
    end
  endgenerate

  // Registered read port toward the flash array
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_buf_data_reg <= 16'h0000;
    end else begin
      flash_buf_data_reg <= page_buf_reg[flash_buf_idx];
    end
  end

  // ----
  // Flash array strobes
  // ----
  // Page number latched with the strobe, held for the whole operation
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_erase_go_reg <= 1'b0;
      flash_write_go_reg <= 1'b0;
      flash_page_reg     <= 8'h00;
    end else begin
      flash_erase_go_reg <= go_erase; // [RULE7]
      flash_write_go_reg <= go_write; // [RULE8]
      if (go_erase || go_write) begin
        flash_page_reg <= page_select_field; // [RULE13]
      end
    end
  end

  // ----
  // Fetch gate
  // ----
  // While busy only the no-read-while-write section answers; the
  // caller must stall or redirect on a deny
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fetch_ok_reg   <= 1'b0;
      fetch_deny_reg <= 1'b0;
    end else begin
      fetch_ok_reg   <= fetch_req && (!rww_section_busy_reg || sect_in_no_read_while_write_section); // [RULE1]
      fetch_deny_reg <= fetch_req && rww_section_busy_reg && !sect_in_no_read_while_write_section; // [RULE1]
    end
  end

  // Boot start follows the accepted fuse strap
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_start_reg <= 14'h0000;
    end else begin
      boot_start_reg <= sect_boot_start; // [RULE16] [RULE18]
    end
  end

  // ----
  // Register read
  // ----
  assign ctrl_view = {1'b0, rww_section_busy_reg, 1'b0, rww_section_reenable_reg,
                      1'b0, page_write_cmd_reg, page_erase_cmd_reg,
                      selfprog_cmd_enable_reg};

  // Data stand in the cycle after the strobe only; unmapped reads zero
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `BSPF_OFF_CTRL:    reg_rdata_reg <= ctrl_view;
        `BSPF_OFF_PTR_LO:  reg_rdata_reg <= ptr_reg[7:0];
        `BSPF_OFF_PTR_HI:  reg_rdata_reg <= ptr_reg[15:8];
        `BSPF_OFF_DATA_LO: reg_rdata_reg <= data_reg[7:0];
        `BSPF_OFF_DATA_HI: reg_rdata_reg <= data_reg[15:8];
        `BSPF_OFF_INFO:    reg_rdata_reg <= {3'h0, buf_load_reg, timer_busy,
                                             eeprom_write_busy, boot_sel};
        default:           reg_rdata_reg <= 8'h00;
      endcase
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end

endmodule

// ===== dv/bspf_ctrl_checker.sv
// Purpose: Port-level checks for the self-programming sequencer.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Bound to bspf_ctrl from the testbench file.
`timescale 1ns/1ps
module bspf_ctrl_checker #(
  parameter [18:0] PROG_CYCLES = 19'd20
) (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Register port and EEPROM status
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        eeprom_write_busy,
  // Fetch check
  input wire        fetch_req,
  input wire        fetch_ok_reg,
  input wire        fetch_deny_reg,
  // Flash side and status
  input wire        flash_erase_go_reg,
  input wire        flash_write_go_reg,
  input wire [7:0]  flash_page_reg,
  input wire        rww_section_busy_reg,
  input wire [13:0] boot_start_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  reg  [19:0] since_go_reg;
  wire        bsy = rww_section_busy_reg;
  // ----
  // Helper count
  // ----
  // Cycles since the last go pulse; saturates so long idles never wrap
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_go_reg <= 20'h00000;
    end else if (flash_erase_go_reg || flash_write_go_reg) begin
      since_go_reg <= 20'h00001;
    end else if (since_go_reg != 20'hFFFFF) begin
      since_go_reg <= since_go_reg + 20'h00001;
    end
  end
  // ----
  // Sequences and assertions
  // ----
  sequence s_go;
    flash_erase_go_reg || flash_write_go_reg;
  endsequence
  sequence s_store;
    reg_wr && reg_addr == 8'h05;
  endsequence
  sequence s_stored;
    $past(reg_wr) && $past(reg_addr) == 8'h05;
  endsequence
  // Re-enable issued only once the timer has surely finished
  sequence s_reen;
    reg_wr && reg_addr == 8'h00 && reg_wdata == 8'h11 && !eeprom_write_busy &&
    since_go_reg > PROG_CYCLES + 1 ##[1:4] s_store;
  endsequence
  chk_erase_busy: assert property (flash_erase_go_reg |-> bsy)
    else $error("erase without busy");
  chk_write_busy: assert property (flash_write_go_reg |-> bsy)
    else $error("write without busy");
  chk_go_cause: assert property (s_go |-> s_stored)
    else $error("go without store");
  chk_go_eeprom: assert property (s_go |-> !$past(eeprom_write_busy))
    else $error("go in EEPROM write");
  chk_go_pulse: assert property (s_go |=> !flash_erase_go_reg && !flash_write_go_reg)
    else $error("long go pulse");
  chk_busy_cause: assert property ($fell(bsy) |-> s_stored)
    else $error("busy cleared without store");
  chk_busy_min: assert property ($fell(bsy) |-> since_go_reg > PROG_CYCLES)
    else $error("busy cleared early");
  chk_reen_clear: assert property (s_reen |=> !bsy)
    else $error("re-enable left busy");
  chk_fetch_deny: assert property (fetch_deny_reg |->
    $past(fetch_req) && $past(bsy) && !fetch_ok_reg) else $error("bad deny");
  chk_fetch_free: assert property ($past(fetch_req) && !$past(bsy) |-> fetch_ok_reg)
    else $error("idle fetch denied");
  chk_page_hold: assert property (!$stable(flash_page_reg) |-> s_go)
    else $error("page moved");
  chk_boot_table: assert property (!$past(rst) |-> boot_start_reg inside {
    14'h1F80, 14'h1F00, 14'h1E00, 14'h1C00, 14'h3F00, 14'h3E00, 14'h3C00, 14'h3800})
    else $error("boot start outside table");
endmodule

// ===== dv/bspf_flash_model.sv
// Purpose: Flash array stand-in that reads out the page buffer.
// Assumes: Buffer data arrives one cycle after the index.
// Notes:   Sweeps all 64 words after each page write pulse.
`timescale 1ns/1ps
module bspf_flash_model (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Array commands
  input  wire        erase_go,
  input  wire        write_go,
  input  wire [15:0] buf_data,
  output wire [5:0]  buf_idx,
  // Observation
  output reg  [7:0]  erase_cnt_reg,
  output reg  [7:0]  write_cnt_reg,
  output reg         sweep_reg
);
  reg  [6:0]  sweep_cnt_reg;
  reg  [15:0] page_mem [0:63];
  wire [6:0]  prev_idx = sweep_cnt_reg - 7'h01;
  assign buf_idx = sweep_cnt_reg[5:0];
  // Count commands and step the read index
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      erase_cnt_reg <= 8'h00;
      write_cnt_reg <= 8'h00;
      sweep_reg <= 1'b0;
      sweep_cnt_reg <= 7'h00;
    end else begin
      if (erase_go) begin
        erase_cnt_reg <= erase_cnt_reg + 8'h01;
      end
      if (write_go) begin
        write_cnt_reg <= write_cnt_reg + 8'h01;
        sweep_reg <= 1'b1;
        sweep_cnt_reg <= 7'h00;
      end else if (sweep_reg) begin
        sweep_cnt_reg <= sweep_cnt_reg + 7'h01;
        if (sweep_cnt_reg == 7'h40) begin
          sweep_reg <= 1'b0;
        end
      end
    end
  end
  // Capture lags the index by one cycle, matching the registered data
  always @(posedge core_clk) begin
    if (sweep_reg && sweep_cnt_reg != 7'h00) begin
      page_mem[prev_idx[5:0]] <= buf_data;
    end
  end
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the self-programming sequencer.
// Assumes: Shortened programming count; small variant until the end.
// Notes:   Boot software is modelled by register port tasks.
`timescale 1ns/1ps
module testbench;
  localparam [18:0] PROG = 19'd20;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         ee_busy = 1'b0;
  reg  [1:0]  boot_sel = 2'h0;
  reg         mid = 1'b0;
  reg         fetch_req = 1'b0;
  reg  [13:0] fetch_addr = 14'h0000;
  wire [7:0]  rdata, page, n_erase, n_write;
  wire        fetch_ok, fetch_deny, erase_go, write_go, busy, sweeping;
  wire [5:0]  buf_idx;
  wire [15:0] buf_data;
  wire [13:0] boot_start;
  integer     n_errors = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     i, c0;
  reg  [7:0]  d;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  bspf_ctrl #(.PROG_CYCLES(PROG)) DUT (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_reg(rdata), .eeprom_write_busy(ee_busy), .boot_size_sel_hi(boot_sel[1]),
    .boot_size_sel_lo(boot_sel[0]), .variant_mid_pin(mid), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ok_reg(fetch_ok), .fetch_deny_reg(fetch_deny),
    .flash_erase_go_reg(erase_go), .flash_write_go_reg(write_go), .flash_page_reg(page),
    .flash_buf_idx(buf_idx), .flash_buf_data_reg(buf_data),
    .rww_section_busy_reg(busy), .boot_start_reg(boot_start));
  bspf_flash_model u_flash (.core_clk(core_clk), .rst(rst), .erase_go(erase_go),
    .write_go(write_go), .buf_data(buf_data), .buf_idx(buf_idx),
    .erase_cnt_reg(n_erase), .write_cnt_reg(n_write), .sweep_reg(sweeping));
  // ----
  // Shared tasks
  // ----
  task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  // Bounded poll of the enable bit; a hang ends the run
  task poll_idle;
    integer k;
    begin
      k = 0;
      rd(8'h00);
      while (d[0] !== 1'b0 && k < 200) begin
        rd(8'h00);
        k = k + 1;
      end
      if (k == 200) begin
        n_errors = n_errors + 1;
        print_verdict;
      end
    end
  endtask
  // Timed pair; the bench keeps EEPROM idle and has no interrupts here
  task do_cmd(input [7:0] v);
    begin
      poll_idle;
      wr(8'h00, v);
      wr(8'h05, 8'h00);
    end
  endtask
  task load(input [5:0] w, input [15:0] v, input z0);
    begin
      wr(8'h03, v[7:0]);
      wr(8'h04, v[15:8]);
      wr(8'h01, {1'b0, w, z0});
      wr(8'h02, 8'h00);
      do_cmd(8'h01);
    end
  endtask
  task fetch(input [13:0] a, input ok);
    begin
      @(posedge core_clk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      @(posedge core_clk);
      fetch_req <= 1'b0;
      #1 check("fetch ok", fetch_ok, ok);
      check("fetch deny", fetch_deny, !ok);
    end
  endtask
  task reen;
    begin
      do_cmd(8'h11);
      #1 check("busy after re-enable", busy, 1'b0);
      rd(8'h00);
      check("ctrl after re-enable", d, 8'h00);
      fetch(14'h0000, 1'b1);
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h00);
    check("ctrl reset", d, 8'h00);
    rd(8'h07);
    check("unmapped read", d, 8'h00);
    $display("test reset done");
    load(6'd0, 16'hA501, 1'b0);
    load(6'd1, 16'h5AC3, 1'b0);
    load(6'd63, 16'hFFEE, 1'b0);
    load(6'd5, 16'h1234, 1'b0);
    rd(8'h00);
    check("ctrl after load", d, 8'h00);
    load(6'd5, 16'hDEAD, 1'b1);
    $display("test load done");
    wr(8'h01, 8'h40);
    wr(8'h02, 8'h01);
    do_cmd(8'h03);
    c0 = cyc;
    #1 check("erase go", erase_go, 1'b1);
    check("erase page", page, 8'h02);
    rd(8'h00);
    check("ctrl erasing", d, 8'h43);
    fetch(14'h0000, 1'b0);
    fetch(14'h1BFF, 1'b0);
    fetch(14'h1C00, 1'b1);
    fetch(14'h3C00, 1'b1);
    poll_idle;
    check("ctrl erased", d, 8'h40);
    check("erase time", (cyc - c0 >= PROG) && (cyc - c0 <= PROG + 5), 1'b1);
    reen;
    $display("test erase done");
    wr(8'h01, 8'h80);
    wr(8'h02, 8'h00);
    do_cmd(8'h05);
    #1 check("write go", write_go, 1'b1);
    check("write page", page, 8'h01);
    poll_idle;
    reen;
    for (i = 0; i < 100 && sweeping; i = i + 1) @(posedge core_clk);
    check("sweep end", sweeping, 1'b0);
    check("word 0", u_flash.page_mem[0], 16'hA501);
    check("word 1", u_flash.page_mem[1], 16'h5AC3);
    check("word 63", u_flash.page_mem[63], 16'hFFEE);
    check("word 5", u_flash.page_mem[5], 16'h1234);
    $display("test write done");
    wr(8'h01, 8'h40);
    wr(8'h02, 8'h01);
    wr(8'h00, 8'h03);
    repeat (5) @(posedge core_clk);
    rd(8'h00);
    check("lapsed ctrl", d, 8'h00);
    wr(8'h05, 8'h00);
    #1 check("lapsed go", erase_go, 1'b0);
    $display("test lapse done");
    @(posedge core_clk);
    ee_busy <= 1'b1;
    wr(8'h00, 8'h03);
    wr(8'h05, 8'h00);
    #1 check("blocked go", erase_go, 1'b0);
    rd(8'h00);
    check("blocked ctrl", d, 8'h00);
    ee_busy <= 1'b0;
    check("erase count", n_erase, 8'h01);
    check("write count", n_write, 8'h01);
    $display("test eeprom done");
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge core_clk);
      mid <= i[2];
      boot_sel <= i[1:0];
      repeat (8) @(posedge core_clk);
      #1 check("boot start", boot_start, i[2] ? 16'h4000 - (16'h0100 << (3 - i[1:0])) :
        16'h2000 - (16'h0080 << (3 - i[1:0])));
    end
    $display("test boot size done");
    print_verdict;
  end
endmodule
bind bspf_ctrl bspf_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.core_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .eeprom_write_busy, .fetch_req, .fetch_ok_reg,
  .fetch_deny_reg, .flash_erase_go_reg, .flash_write_go_reg, .flash_page_reg,
  .rww_section_busy_reg, .boot_start_reg);
